// *** hdl/reset_and_watchdog_control.sv ***
`timescale 1ns/1ns
module reset_and_watchdog_control #(
	parameter int unsigned POR_DELAY_CYCLES = rst_wdt_pkg::POR_DELAY_CYC,
	parameter int unsigned WDT_DELAY_CYCLES = rst_wdt_pkg::WDT_DELAY_CYC
) (
	input  wire logic                           i_ref_clk,
	input  wire logic                           i_rst,
	input  wire logic                           i_psel,
	input  wire logic                           i_penable,
	input  wire logic                           i_pwrite,
	input  wire logic [rst_wdt_pkg::ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]                    i_pwdata,
	output logic      [31:0]                    o_prdata,
	output logic                                o_pready,
	output logic                                o_pslverr,
	input  wire logic                           i_low_speed_internal_osc_tick,
	input  wire logic                           i_supply_low,
	input  wire logic                           i_power_down,
	input  wire logic                           i_sleep_idle,
	input  wire logic                           i_halt,
	input  wire logic                           i_clear_watchdog_instruction,
	output logic                                o_full_reset,
	output logic                                o_pc_sp_reset,
	output logic                                o_port_load_ones,
	output logic                                o_cpu_hold,
	output logic                                o_brownout_enable,
	output logic      [1:0]                     o_brownout_threshold_sel,
	output logic                                o_idle_sysclk_enable
);
	import rst_wdt_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		seq_state_e             st;
		logic [7:0]             wdt_ctrl;
		logic [7:0]             level;
		logic                   idle_clk;
		logic                   f_bor;
		logic                   f_lvl;
		logic                   f_key;
		logic                   to;
		logic [WDT_CNT_W-1:0]   wdt_cnt;
		logic [7:0]             bor_cnt;
		logic [1:0]             ticks;
		logic                   c_bor;
		logic                   c_lvl;
		logic                   c_key;
		logic [DELAY_W-1:0]     dly;
		logic                   pready;
		logic                   pslverr;
		logic [31:0]            prdata;
		logic                   full_reset;
		logic                   pc_sp_reset;
		logic                   port_ones;
		logic                   cpu_hold;
		logic                   bor_en;
		logic [1:0]             thr;
	} state_s;

	localparam logic [DELAY_W-1:0] POR_DLY = DELAY_W'(POR_DELAY_CYCLES - 1);
	localparam logic [DELAY_W-1:0] WDT_DLY = DELAY_W'(WDT_DELAY_CYCLES - 1);

	// power-on: held in the restart delay with PC cleared and ports set as inputs
	localparam state_s RST_VAL = '{
		st:         ST_DELAY,
		wdt_ctrl:   WDT_CTRL_POR,
		level:      LEVEL_POR,
		dly:        POR_DLY,
		full_reset: 1'b1,
		port_ones:  1'b1,
		cpu_hold:   1'b1,
		bor_en:     1'b1,
		default:    '0
	};

	state_s cur_reg;
	state_s cur_next;

	// ==========================================================
	// decoding helpers
	function automatic logic key_valid(input logic [4:0] key);
		return (key == KEY_ENABLE) || (key == KEY_DISABLE);
	endfunction

	// returns {valid, threshold select}
	function automatic logic [2:0] level_decode(input logic [7:0] lvl);
		unique case (lvl)
			LEVEL_2V10: return 3'h4;
			LEVEL_2V55: return 3'h5;
			LEVEL_3V15: return 3'h6;
			LEVEL_3V80: return 3'h7;
			default:    return 3'h0;
		endcase
	endfunction

	// terminal count of the prescaled watchdog counter
	function automatic logic [WDT_CNT_W-1:0] wdt_limit(input logic [2:0] sel);
		logic [4:0] e;
		unique case (sel)
			3'h0:    e = 5'h08;
			3'h1:    e = 5'h0A;
			3'h2:    e = 5'h0C;
			3'h3:    e = 5'h0E;
			3'h4:    e = 5'h0F;
			3'h5:    e = 5'h10;
			3'h6:    e = 5'h11;
			default: e = 5'h12;
		endcase
		return WDT_CNT_W'((19'h00001 << e) - 19'h00001);
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		logic       acc;
		logic       wr;
		logic       clr;
		logic       wdt_on;
		logic       ovf;
		logic       ovf_full;
		logic       bor_q;
		logic       bad_key;
		logic       bad_lvl;
		logic       fire_long;
		logic [2:0] lv;
		acc       = i_psel & i_penable;
		wr        = acc & cur_reg.pready & i_pwrite;
		clr       = i_clear_watchdog_instruction | i_halt;
		wdt_on    = cur_reg.wdt_ctrl[KEY_MSB:KEY_LSB] == KEY_ENABLE;
		lv        = level_decode(cur_reg.level);
		bad_key   = !key_valid(cur_reg.wdt_ctrl[KEY_MSB:KEY_LSB]);
		bad_lvl   = !lv[2];
		bor_q     = 1'b0;
		fire_long = 1'b0;
		ovf       = 1'b0;
		ovf_full  = 1'b0;
		cur_next  = cur_reg;

		cur_next.full_reset  = 1'b0;
		cur_next.pc_sp_reset = 1'b0;
		cur_next.port_ones   = 1'b0;
		cur_next.bor_en      = !i_power_down;
		cur_next.thr         = lv[1:0];

		// ======================================================
		// bus slave: answer one cycle into the access phase
		cur_next.pready  = acc & !cur_reg.pready;
		cur_next.pslverr = 1'b0;
		if (acc && !cur_reg.pready) begin
			unique case (i_paddr)
				OFS_WDT_CTRL: cur_next.prdata = {24'h000000, cur_reg.wdt_ctrl};
				OFS_LEVEL:    cur_next.prdata = {24'h000000, cur_reg.level};
				OFS_FLAGS:    cur_next.prdata = {24'h000000, cur_reg.idle_clk, 4'h0,
					cur_reg.f_bor, cur_reg.f_lvl, cur_reg.f_key};
				OFS_STATUS:   cur_next.prdata = {30'h00000000, wdt_on, cur_reg.to};
				default: begin
					cur_next.prdata  = 32'h00000000;
					cur_next.pslverr = 1'b1;
				end
			endcase
		end
		if (wr) begin
			unique case (i_paddr)
				OFS_WDT_CTRL: begin
					cur_next.wdt_ctrl = i_pwdata[7:0];
					if (!key_valid(i_pwdata[KEY_MSB:KEY_LSB])) begin
						cur_next.wdt_cnt = '0;
					end
				end
				OFS_LEVEL: cur_next.level = i_pwdata[7:0];
				OFS_FLAGS: begin
					cur_next.idle_clk = i_pwdata[FLAG_IDLE_CLK];
					// writing 1 leaves a flag as it is; only 0 clears
					cur_next.f_bor = cur_reg.f_bor & i_pwdata[FLAG_BOR];
					cur_next.f_lvl = cur_reg.f_lvl & i_pwdata[FLAG_LVL];
					cur_next.f_key = cur_reg.f_key & i_pwdata[FLAG_KEY];
				end
				default: ;
			endcase
		end

		// ======================================================
		// watchdog
		if (clr) begin
			cur_next.wdt_cnt = '0;
			cur_next.to      = 1'b0;
		end
		// a clear in the overflow cycle counts as cleared in time
		ovf = (cur_reg.st == ST_RUN) && wdt_on && i_low_speed_internal_osc_tick && !clr
			&& (cur_reg.wdt_cnt == wdt_limit(cur_reg.wdt_ctrl[SEL_MSB:0]));
		ovf_full = ovf && !i_sleep_idle;
		if ((cur_reg.st == ST_RUN) && wdt_on && i_low_speed_internal_osc_tick && !clr && !wr) begin
			cur_next.wdt_cnt = ovf ? '0 : cur_reg.wdt_cnt + 1'b1;
		end
		if (ovf) begin
			cur_next.to = 1'b1;
			cur_next.pc_sp_reset = i_sleep_idle;
		end

		// ======================================================
		// brownout qualification filter
		if (i_supply_low && !i_power_down && (cur_reg.st != ST_DELAY)) begin
			if (cur_reg.bor_cnt == BOR_QUAL_LAST) begin
				bor_q = 1'b1;
			end else begin
				cur_next.bor_cnt = cur_reg.bor_cnt + 8'h01;
			end
		end else begin
			cur_next.bor_cnt = 8'h00;
		end

		// ======================================================
		// reset sequencer
		unique case (cur_reg.st)
			ST_RUN: begin
				if (!ovf_full && (bad_key || bad_lvl || bor_q)) begin
					cur_next.st    = ST_ARM;
					cur_next.ticks = 2'h0;
					cur_next.c_key = bad_key;
					cur_next.c_lvl = bad_lvl;
					cur_next.c_bor = bor_q;
				end
			end
			ST_ARM: begin
				cur_next.c_key = cur_reg.c_key | bad_key;
				cur_next.c_lvl = cur_reg.c_lvl | bad_lvl;
				cur_next.c_bor = cur_reg.c_bor | bor_q;
				// counting whole ticks gives 2~3 low-speed periods of latency
				if (i_low_speed_internal_osc_tick) begin
					if (cur_reg.ticks == FAULT_TICK_LAST) begin
						fire_long = 1'b1;
					end else begin
						cur_next.ticks = cur_reg.ticks + 2'h1;
					end
				end
			end
			ST_DELAY: begin
				if (cur_reg.dly == '0) begin
					cur_next.st       = ST_RUN;
					cur_next.cpu_hold = 1'b0;
				end else begin
					cur_next.dly = cur_reg.dly - 1'b1;
				end
			end
		endcase

		if (fire_long || ovf_full) begin
			cur_next.st         = ST_DELAY;
			cur_next.dly        = fire_long ? POR_DLY : WDT_DLY;
			cur_next.full_reset = 1'b1;
			cur_next.cpu_hold   = 1'b1;
			cur_next.wdt_ctrl   = WDT_CTRL_POR;
			cur_next.wdt_cnt    = '0;
			if (fire_long) begin
				// flags set after the software write so the set wins
				cur_next.f_bor = cur_next.f_bor | cur_next.c_bor;
				cur_next.f_lvl = cur_next.f_lvl | cur_next.c_lvl;
				cur_next.f_key = cur_next.f_key | cur_next.c_key;
				if (cur_next.c_lvl) begin
					cur_next.level = LEVEL_POR;
				end
			end
			cur_next.c_key = 1'b0;
			cur_next.c_lvl = 1'b0;
			cur_next.c_bor = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cur_reg <= RST_VAL;
		end else begin
			cur_reg <= cur_next;
		end
	end

	// ==========================================================
	// outputs
	assign o_prdata                 = cur_reg.prdata;
	assign o_pready                 = cur_reg.pready;
	assign o_pslverr                = cur_reg.pslverr;
	assign o_full_reset             = cur_reg.full_reset;
	assign o_pc_sp_reset            = cur_reg.pc_sp_reset;
	assign o_port_load_ones         = cur_reg.port_ones;
	assign o_cpu_hold               = cur_reg.cpu_hold;
	assign o_brownout_enable        = cur_reg.bor_en;
	assign o_brownout_threshold_sel = cur_reg.thr;
	assign o_idle_sysclk_enable     = cur_reg.idle_clk;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	logic [WDT_CNT_W-1:0] chk_limit;
	logic                 chk_wr_wdt;
	assign chk_limit  = wdt_limit(cur_reg.wdt_ctrl[SEL_MSB:0]);
	assign chk_wr_wdt = i_psel && i_penable && o_pready && i_pwrite && (i_paddr == OFS_WDT_CTRL);
	logic                 chk_wr_lvl;
	logic                 chk_lvl_ok;
	logic                 chk_ovf;
	logic                 chk_fire;
	assign chk_wr_lvl = i_psel && i_penable && o_pready && i_pwrite && (i_paddr == OFS_LEVEL);
	assign chk_lvl_ok = level_decode(cur_reg.level) != 3'h0;
	// overflow tick with no clear pending; sleep decides which reset follows
	assign chk_ovf    = (cur_reg.st == ST_RUN) && i_low_speed_internal_osc_tick
		&& (cur_reg.wdt_ctrl[KEY_MSB:KEY_LSB] == KEY_ENABLE) && (cur_reg.wdt_cnt == chk_limit)
		&& !i_halt && !i_clear_watchdog_instruction;
	assign chk_fire   = (cur_reg.st == ST_ARM) && i_low_speed_internal_osc_tick
		&& (cur_reg.ticks == FAULT_TICK_LAST);

	chk_key_disable_hold: assert property (
		(cur_reg.wdt_ctrl[KEY_MSB:KEY_LSB] == KEY_DISABLE) && !chk_wr_wdt
		|=> (cur_reg.wdt_cnt == $past(cur_reg.wdt_cnt)) || (cur_reg.wdt_cnt == '0))
		else $error("disabled watchdog counted");
	chk_bad_key_arms: assert property (
		(cur_reg.st == ST_RUN) && !key_valid(cur_reg.wdt_ctrl[KEY_MSB:KEY_LSB])
		|=> (cur_reg.st == ST_ARM) || o_full_reset)
		else $error("invalid key did not start the fault delay");
	chk_wdt_ovf_reset: assert property (
		chk_ovf && !i_sleep_idle
		|=> o_full_reset && o_cpu_hold && cur_reg.to ##1 !o_full_reset)
		else $error("running overflow did not reset with timeout flag");
	chk_sleep_ovf: assert property (
		chk_ovf && i_sleep_idle
		|=> o_pc_sp_reset && !o_full_reset && cur_reg.to && !o_cpu_hold)
		else $error("sleep overflow behaved wrongly");
	chk_clear_count: assert property (
		i_clear_watchdog_instruction || i_halt |=> cur_reg.wdt_cnt == '0)
		else $error("watchdog count not cleared");
	chk_delay_release: assert property (
		(cur_reg.st == ST_DELAY) && (cur_reg.dly == '0) |=> !o_cpu_hold ##1 !o_cpu_hold)
		else $error("restart delay did not end");
	chk_bor_glitch: assert property (
		!i_supply_low || i_power_down |=> (cur_reg.bor_cnt == 8'h00) && !cur_reg.c_bor
		|| (cur_reg.st != ST_RUN))
		else $error("short low-supply pulse was not dropped");
	chk_level_restore: assert property (
		chk_fire && !chk_lvl_ok
		|=> (cur_reg.level == LEVEL_POR) && cur_reg.f_lvl && o_full_reset)
		else $error("level fault did not restore field");
	chk_bor_flag_wins: assert property (
		chk_fire && cur_reg.c_bor && !cur_reg.c_lvl && chk_lvl_ok && !chk_wr_lvl
		|=> cur_reg.f_bor && $stable(cur_reg.level))
		else $error("brownout flag lost");
	chk_flags_zero: assert property (
		o_pready && (i_paddr == OFS_FLAGS) |-> o_prdata[6:3] == 4'h0)
		else $error("unimplemented flag bits read nonzero");

	cov_wdt_full: cover property ($rose(o_full_reset) && cur_reg.to);
	cov_sleep_wake: cover property (o_pc_sp_reset);
	cov_bor_reset: cover property ((cur_reg.st == ST_ARM) ##[1:300] $rose(cur_reg.f_bor));
	cov_key_fault: cover property ($rose(cur_reg.f_key));

endmodule

// *** shared/rst_wdt_pkg.sv ***
package rst_wdt_pkg;

	// ==========================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned POR_DELAY_US    = 50000;
	localparam int unsigned WDT_DELAY_US    = 16700;
	localparam int unsigned POR_DELAY_CYC   = POR_DELAY_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned WDT_DELAY_CYC   = WDT_DELAY_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned DELAY_W         = 23;
	// last cycle index of the low-supply qualification time, in clock cycles
	localparam logic [7:0]  BOR_QUAL_LAST   = 8'h0F;
	// last low-speed tick index of the 2~3 tick fault delay
	localparam logic [1:0]  FAULT_TICK_LAST = 2'h2;
	localparam int unsigned WDT_CNT_W       = 18;

	// ==========================================================
	// register map (byte addresses)
	localparam int unsigned ADDR_W          = 8;
	localparam logic [7:0]  OFS_WDT_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_LEVEL       = 8'h04;
	localparam logic [7:0]  OFS_FLAGS       = 8'h08;
	localparam logic [7:0]  OFS_STATUS      = 8'h0C;

	// ==========================================================
	// fields and reset values
	localparam int unsigned KEY_MSB         = 7;
	localparam int unsigned KEY_LSB         = 3;
	localparam int unsigned SEL_MSB         = 2;
	localparam logic [4:0]  KEY_DISABLE     = 5'h15;
	localparam logic [4:0]  KEY_ENABLE      = 5'h0A;
	localparam logic [7:0]  WDT_CTRL_POR    = 8'h53;
	localparam logic [7:0]  LEVEL_POR       = 8'h55;
	localparam logic [7:0]  LEVEL_2V10      = 8'h55;
	localparam logic [7:0]  LEVEL_2V55      = 8'h33;
	localparam logic [7:0]  LEVEL_3V15      = 8'h99;
	localparam logic [7:0]  LEVEL_3V80      = 8'hAA;
	localparam int unsigned FLAG_IDLE_CLK   = 7;
	localparam int unsigned FLAG_BOR        = 2;
	localparam int unsigned FLAG_LVL        = 1;
	localparam int unsigned FLAG_KEY        = 0;
	localparam int unsigned STAT_TO         = 0;
	localparam int unsigned STAT_WDT_ON     = 1;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_ARM,
		ST_DELAY
	} seq_state_e;

endpackage

// *** test/reset_and_watchdog_control_tb.sv ***
`timescale 1ns/1ns
module reset_and_watchdog_control_tb;
	import rst_wdt_pkg::*;
	// ==========
	// signals and model state
	// short restart delays keep the run small; expectations use these values
	localparam int         POR_D     = 20;
	localparam int         WDT_D     = 10;
	localparam logic [7:0] CODES [4] = '{LEVEL_2V10, LEVEL_2V55, LEVEL_3V15, LEVEL_3V80};
	logic        i_ref_clk, i_rst, i_psel, i_penable, i_pwrite;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata;
	logic [31:0] o_prdata;
	logic        o_pready, o_pslverr, o_full_reset, o_pc_sp_reset, o_port_load_ones;
	logic        i_low_speed_internal_osc_tick, i_supply_low, i_power_down, i_sleep_idle, i_halt;
	logic        i_clear_watchdog_instruction;
	logic        o_cpu_hold, o_brownout_enable, o_idle_sysclk_enable;
	logic [1:0]  o_brownout_threshold_sel;
	logic [31:0] rd;
	logic        err;
	logic [15:0] lfsr_q;
	int          num_errors, compares, hold_run, last_hold, at, kind;
	int          m_ctrl, m_level, m_flags, m_to;
	int          wdt_bits [$] = '{8, 10};

	reset_and_watchdog_control #(.POR_DELAY_CYCLES(POR_D), .WDT_DELAY_CYCLES(WDT_D)) DUT (
		.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_low_speed_internal_osc_tick(i_low_speed_internal_osc_tick),
		.i_supply_low(i_supply_low), .i_power_down(i_power_down), .i_sleep_idle(i_sleep_idle),
		.i_halt(i_halt), .i_clear_watchdog_instruction(i_clear_watchdog_instruction),
		.o_full_reset(o_full_reset), .o_pc_sp_reset(o_pc_sp_reset),
		.o_port_load_ones(o_port_load_ones), .o_cpu_hold(o_cpu_hold),
		.o_brownout_enable(o_brownout_enable),
		.o_brownout_threshold_sel(o_brownout_threshold_sel),
		.o_idle_sysclk_enable(o_idle_sysclk_enable)
	);

	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	// length of each restart hold, measured outside of reset
	always @(posedge i_ref_clk) begin
		if (!i_rst && o_cpu_hold === 1'b1) begin
			hold_run <= hold_run + 1;
		end else if (hold_run != 0) begin
			last_hold <= hold_run;
			hold_run  <= 0;
		end
	end

	// ==========
	// tasks
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int k;
		@(posedge i_ref_clk);
		i_psel    <= 1'b1;
		i_pwrite  <= w;
		i_paddr   <= a;
		i_pwdata  <= d;
		@(posedge i_ref_clk);
		i_penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge i_ref_clk);
			if (o_pready === 1'b1) break;
		end
		q = o_prdata;
		e = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
		if (k == 20) begin
			num_errors++;
			end_of_test();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, err);
	endtask

	task automatic rdc(input logic [7:0] a, input int exp, input logic exp_err);
		apb(1'b0, a, 32'h0, rd, err);
		chk($sformatf("reg %h", a), exp_err ? 0 : exp, rd);
		chk("pslverr", exp_err, err);
	endtask

	task automatic rd_all();
		rdc(OFS_WDT_CTRL, m_ctrl, 1'b0);
		rdc(OFS_LEVEL, m_level, 1'b0);
		rdc(OFS_FLAGS, m_flags, 1'b0);
		rdc(OFS_STATUS, m_to + 2 * ((m_ctrl >> 3) == KEY_ENABLE), 1'b0);
	endtask

	// ticks three cycles apart, so a reset pulse belongs to the tick just given
	task automatic run_ticks(input int max, input int exp_at, input int exp_kind);
		at   = 0;
		kind = 0;
		for (int t = 1; t <= max && at == 0; t++) begin
			@(posedge i_ref_clk);
			i_low_speed_internal_osc_tick <= 1'b1;
			@(posedge i_ref_clk);
			i_low_speed_internal_osc_tick <= 1'b0;
			@(posedge i_ref_clk);
			if (o_full_reset === 1'b1 || o_pc_sp_reset === 1'b1) begin
				at   = t;
				kind = (o_full_reset === 1'b1) ? 1 : 2;
			end
		end
		chk("tick_count", exp_at, at);
		chk("reset_kind", exp_kind, kind);
	endtask

	task automatic wait_idle(input int d);
		int k;
		// sampled mid-cycle so the hold level is settled
		for (k = 0; k < 300; k++) begin
			@(negedge i_ref_clk);
			if (o_cpu_hold === 1'b0) break;
		end
		@(posedge i_ref_clk);
		@(posedge i_ref_clk);
		chk("hold_len", 1, k < 300 && last_hold >= d && last_hold <= d + 3);
		if (k == 300) end_of_test();
	endtask

	task automatic pulse(input logic halt);
		@(posedge i_ref_clk);
		if (halt) i_halt <= 1'b1;
		else i_clear_watchdog_instruction <= 1'b1;
		@(posedge i_ref_clk);
		i_halt <= 1'b0;
		i_clear_watchdog_instruction <= 1'b0;
	endtask

	// ==========
	// sequence
	initial begin
		{i_rst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = {1'b1, 43'h0};
		{i_low_speed_internal_osc_tick, i_supply_low, i_power_down, i_sleep_idle, i_halt} = 5'h00;
		i_clear_watchdog_instruction = 1'b0;
		{num_errors, compares, hold_run, last_hold} = {32'h0, 32'h0, 32'h0, 32'h0};
		lfsr_q = 16'hEE9D;
		{m_ctrl, m_level, m_flags, m_to} = {32'(WDT_CTRL_POR), 32'(LEVEL_POR), 32'h0, 32'h0};
		repeat (12) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(negedge i_ref_clk);
		chk("full_reset", 1, o_full_reset);
		chk("port_ones", 1, o_port_load_ones);
		chk("cpu_hold", 1, o_cpu_hold);
		@(negedge i_ref_clk);
		chk("full_reset", 0, o_full_reset);
		chk("port_ones", 0, o_port_load_ones);
		wait_idle(POR_D);
		rd_all();
		rdc(8'h10, 0, 1'b1);
		$display("test power_on done");
		lfsr_q = lfsr(lfsr_q);
		wr(OFS_FLAGS, {lfsr_q, 16'h00FF});
		m_flags = 8'h80;
		rd_all();
		chk("idle_clk", 1, o_idle_sysclk_enable);
		wr(OFS_FLAGS, 32'h0);
		m_flags = 0;
		foreach (CODES[i]) begin
			wr(OFS_LEVEL, CODES[i]);
			m_level = CODES[i];
			rd_all();
			chk("thr_sel", i, o_brownout_threshold_sel);
		end
		$display("test registers done");
		repeat (3) begin
			lfsr_q = lfsr(lfsr_q);
			@(posedge i_ref_clk);
			i_supply_low <= 1'b1;
			repeat (1 + lfsr_q % 15) @(posedge i_ref_clk);
			i_supply_low <= 1'b0;
			run_ticks(4, 0, 0);
		end
		i_power_down <= 1'b1;
		i_supply_low <= 1'b1;
		repeat (40) @(posedge i_ref_clk);
		chk("bor_en", 0, o_brownout_enable);
		run_ticks(4, 0, 0);
		i_power_down <= 1'b0;
		i_supply_low <= 1'b0;
		wr(OFS_LEVEL, LEVEL_3V15);
		chk("bor_en", 1, o_brownout_enable);
		m_level = LEVEL_3V15;
		i_supply_low <= 1'b1;
		repeat (20) @(posedge i_ref_clk);
		run_ticks(5, 3, 1);
		i_supply_low <= 1'b0;
		wait_idle(POR_D);
		m_flags = m_flags | 4;
		rd_all();
		$display("test brownout done");
		wr(OFS_LEVEL, 32'h12);
		run_ticks(5, 3, 1);
		wait_idle(POR_D);
		m_level = LEVEL_POR;
		m_flags = m_flags | 2;
		rd_all();
		wr(OFS_WDT_CTRL, 32'hFB);
		run_ticks(5, 3, 1);
		wait_idle(POR_D);
		m_flags = m_flags | 1;
		rd_all();
		wr(OFS_FLAGS, 32'h07);
		rd_all();
		wr(OFS_FLAGS, 32'h0);
		m_flags = 0;
		rd_all();
		$display("test faults done");
		foreach (wdt_bits[i]) begin
			wr(OFS_WDT_CTRL, {KEY_ENABLE, 3'(i)});
			pulse(1'b0);
			run_ticks((1 << wdt_bits[i]) + 40, 1 << wdt_bits[i], 1);
			wait_idle(WDT_D);
			{m_to, m_ctrl} = {32'h1, 32'(WDT_CTRL_POR)};
			rd_all();
			pulse(1'b0);
			m_to = 0;
			rd_all();
		end
		for (int m = 0; m < 2; m++) begin
			wr(OFS_WDT_CTRL, {KEY_ENABLE, 3'h0});
			pulse(m);
			run_ticks(200, 0, 0);
			pulse(m);
			run_ticks(300, 256, 1);
			wait_idle(WDT_D);
			pulse(1'b0);
		end
		$display("test watchdog done");
		i_sleep_idle <= 1'b1;
		wr(OFS_WDT_CTRL, {KEY_ENABLE, 3'h0});
		pulse(1'b0);
		run_ticks(300, 256, 2);
		i_sleep_idle <= 1'b0;
		{m_to, m_ctrl} = {32'h1, 32'(KEY_ENABLE) << 3};
		rd_all();
		pulse(1'b0);
		m_to = 0;
		wr(OFS_WDT_CTRL, {KEY_DISABLE, 3'h0});
		m_ctrl = 32'(KEY_DISABLE) << 3;
		rd_all();
		run_ticks(300, 0, 0);
		$display("test sleep_disable done");
		end_of_test();
	end
endmodule
